// ### verilog/ftcr_pkg.sv
`default_nettype none
package ftcr_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CFG       = 8'h03;
	localparam logic [7:0] IDX_ONESHOT   = 8'h0F;
	localparam logic [7:0] IDX_CRIT      = 8'h19;
	localparam logic [7:0] IDX_CNT_LO    = 8'h46;
	localparam logic [7:0] IDX_CNT_HI    = 8'h47;
	localparam logic [7:0] IDX_CTRL      = 8'h60;
	localparam logic [7:0] IDX_HI_LIM    = 8'h61;
	localparam logic [7:0] IDX_LO_LIM    = 8'h62;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h63;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h64;
	// configuration fields
	localparam int CFG_ALERT_MASK  = 7;
	localparam int CFG_STANDBY     = 6;
	localparam int CFG_PWM_STBY_DIS = 5;
	localparam int CFG_TACH_SEL    = 2;
	localparam int CFG_CRIT_UNLOCK = 1;
	localparam int CFG_FAULT_QUEUE = 0;
	localparam logic [7:0] CFG_WR_MASK = 8'hE7;
	// own control fields
	localparam int CTRL_PWM_POL    = 0;
	localparam int CTRL_PWM_360K   = 1;
	// interrupt status fields
	localparam int IRQ_ALERT       = 0;
	localparam int IRQ_TACH_DONE   = 1;
	localparam int IRQ_W           = 2;
	// reset values
	localparam logic [7:0] CRIT_RST    = 8'h55;
	localparam logic [7:0] HI_LIM_RST  = 8'h46;
	localparam logic [7:0] LO_LIM_RST  = 8'h00;
	localparam logic [1:0] EDGE_RST    = 2'h0;
	// edge count codes
	localparam logic [1:0] EDGE_2      = 2'h1;
	localparam logic [1:0] EDGE_3      = 2'h2;
	localparam logic [1:0] EDGE_5      = 2'h3;
	localparam logic [2:0] FAULT_QUEUE_LEN = 3'h3;
	// timing
	localparam int CLK_HZ          = 125_000_000;
	localparam int TACH_TICK_HZ    = 90_000;
	localparam int TACH_TICK_DIV   = CLK_HZ / TACH_TICK_HZ;
endpackage
`default_nettype wire

// ### verilog/ftcr_top.sv
`timescale 1ns/10ps
`default_nettype none
module ftcr_top #(
	parameter int TICK_DIV = ftcr_pkg::TACH_TICK_DIV,
	parameter int AW       = 12
) (
	input  wire logic          i_ref_clk,
	input  wire logic          i_reset,
	input  wire logic          i_psel,
	input  wire logic          i_penable,
	input  wire logic          i_pwrite,
	input  wire logic [AW-1:0] i_paddr,
	input  wire logic [31:0]   i_pwdata,
	output logic               o_pready,
	output logic [31:0]        o_prdata,
	output logic               o_pslverr,
	input  wire logic          i_pwm_wave,
	output logic               o_pwm,
	output logic               o_continuous,
	output logic               o_conv_start,
	input  wire logic          i_conv_done,
	input  wire logic [7:0]    i_remote_temp,
	output logic [7:0]         o_critical_temp_limit,
	input  wire logic          i_alert_tach_in,
	output logic               o_alert_tach_out,
	output logic               o_alert_tach_oe,
	output logic               o_irq
);
	// upper address bits are decoded as a range, so at least one must exist
	if (TICK_DIV < 2 || AW < 11) begin : g_bad_param
		$error("ftcr_top: TICK_DIV must be >= 2 and AW >= 11");
	end

	//--------------------------------------------------------------
	// register bus decode
	//--------------------------------------------------------------
	logic        setup;
	logic        wr_en;
	logic [7:0]  idx;
	logic        idx_ok;
	logic        hi_word_ok;

	assign setup      = i_psel & ~i_penable;
	assign wr_en      = i_psel & i_penable & i_pwrite;
	assign idx        = i_paddr[9:2];
	assign hi_word_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[AW-1:10] == '0);
	assign o_pready   = 1'b1;

	always_comb begin
		case (idx)
			ftcr_pkg::IDX_CFG, ftcr_pkg::IDX_ONESHOT, ftcr_pkg::IDX_CRIT,
			ftcr_pkg::IDX_CNT_LO, ftcr_pkg::IDX_CNT_HI, ftcr_pkg::IDX_CTRL,
			ftcr_pkg::IDX_HI_LIM, ftcr_pkg::IDX_LO_LIM, ftcr_pkg::IDX_IRQ_STAT,
			ftcr_pkg::IDX_IRQ_MASK: idx_ok = hi_word_ok;
			default: idx_ok = 1'b0;
		endcase
	end

	//--------------------------------------------------------------
	// software registers
	//--------------------------------------------------------------
	logic [7:0] cfg_ff;
	logic [1:0] ctrl_ff;
	logic [7:0] hi_lim_ff;
	logic [7:0] lo_lim_ff;
	logic [1:0] edge_sel_ff;
	logic [7:0] crit_ff;
	logic       crit_locked_ff;

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			cfg_ff      <= 8'h00;
			ctrl_ff     <= 2'h0;
			hi_lim_ff   <= ftcr_pkg::HI_LIM_RST;
			lo_lim_ff   <= ftcr_pkg::LO_LIM_RST;
			edge_sel_ff <= ftcr_pkg::EDGE_RST;
		end else if (wr_en && idx_ok) begin
			case (idx)
				// unused bits are never stored, so they read zero
				ftcr_pkg::IDX_CFG:    cfg_ff      <= i_pwdata[7:0] & ftcr_pkg::CFG_WR_MASK;
				ftcr_pkg::IDX_CTRL:   ctrl_ff     <= i_pwdata[1:0];
				ftcr_pkg::IDX_HI_LIM: hi_lim_ff   <= i_pwdata[7:0];
				ftcr_pkg::IDX_LO_LIM: lo_lim_ff   <= i_pwdata[7:0];
				ftcr_pkg::IDX_CNT_LO: edge_sel_ff <= i_pwdata[1:0];
				default: ;
			endcase
		end
	end

	// lock survives everything but reset, which stands for power cycling
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			crit_ff        <= ftcr_pkg::CRIT_RST;
			crit_locked_ff <= 1'b0;
		end else if (wr_en && idx_ok && idx == ftcr_pkg::IDX_CRIT &&
		             cfg_ff[ftcr_pkg::CFG_CRIT_UNLOCK] && !crit_locked_ff) begin
			crit_ff        <= i_pwdata[7:0];
			crit_locked_ff <= 1'b1;
		end
	end
	assign o_critical_temp_limit = crit_ff;

	//--------------------------------------------------------------
	// standby, conversions and pwm
	//--------------------------------------------------------------
	logic conv_start_ff;

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			conv_start_ff <= 1'b0;
		end else begin
			conv_start_ff <= wr_en && idx_ok && idx == ftcr_pkg::IDX_ONESHOT;
		end
	end
	assign o_conv_start = conv_start_ff;
	assign o_continuous = ~cfg_ff[ftcr_pkg::CFG_STANDBY];

	// inactive level equals the polarity bit
	assign o_pwm = (cfg_ff[ftcr_pkg::CFG_STANDBY] && cfg_ff[ftcr_pkg::CFG_PWM_STBY_DIS]) ?
	               ctrl_ff[ftcr_pkg::CTRL_PWM_POL] : i_pwm_wave;

	//--------------------------------------------------------------
	// limit compare and fault queue
	//--------------------------------------------------------------
	logic       out_of_lim;
	logic [1:0] fault_cnt_ff;
	logic       alert_ff;
	logic       alert_evt;
	logic [1:0] nxt_fault_cnt;

	assign out_of_lim = ($signed(i_remote_temp) > $signed(hi_lim_ff)) ||
	                    ($signed(i_remote_temp) < $signed(lo_lim_ff));

	always_comb begin
		if (!out_of_lim) begin
			nxt_fault_cnt = 2'h0;
		end else if (fault_cnt_ff == ftcr_pkg::FAULT_QUEUE_LEN[1:0]) begin
			nxt_fault_cnt = fault_cnt_ff;
		end else begin
			nxt_fault_cnt = fault_cnt_ff + 2'h1;
		end
	end

	// alert state follows each conversion result
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			fault_cnt_ff <= 2'h0;
			alert_ff     <= 1'b0;
		end else if (i_conv_done) begin
			fault_cnt_ff <= nxt_fault_cnt;
			if (cfg_ff[ftcr_pkg::CFG_FAULT_QUEUE]) begin
				alert_ff <= (nxt_fault_cnt == ftcr_pkg::FAULT_QUEUE_LEN[1:0]);
			end else begin
				alert_ff <= out_of_lim;
			end
		end
	end
	assign alert_evt = i_conv_done && !alert_ff &&
	                   (cfg_ff[ftcr_pkg::CFG_FAULT_QUEUE] ?
	                    (nxt_fault_cnt == ftcr_pkg::FAULT_QUEUE_LEN[1:0]) : out_of_lim);

	// open drain: only ever pulls low
	assign o_alert_tach_out = 1'b0;
	assign o_alert_tach_oe  = alert_ff && !cfg_ff[ftcr_pkg::CFG_ALERT_MASK] &&
	                          !cfg_ff[ftcr_pkg::CFG_TACH_SEL];

	//--------------------------------------------------------------
	// tachometer period measurement
	//--------------------------------------------------------------
	logic [$clog2(TICK_DIV)-1:0] tick_cnt_ff;
	logic        tick;
	logic        tach_d_ff;
	logic        tach_edge;
	logic [2:0]  edge_cnt_ff;
	logic [2:0]  edges_needed;
	logic [2:0]  scale;
	logic [15:0] period_ff;
	logic [15:0] meas_ff;
	logic        meas_evt;
	logic [16:0] period_sum;

	assign tick      = (tick_cnt_ff == ($clog2(TICK_DIV))'(TICK_DIV - 1));
	assign tach_edge = i_alert_tach_in & ~tach_d_ff & cfg_ff[ftcr_pkg::CFG_TACH_SEL];

	always_comb begin
		case (edge_sel_ff)
			ftcr_pkg::EDGE_2: begin edges_needed = 3'd2; scale = 3'd4; end
			ftcr_pkg::EDGE_3: begin edges_needed = 3'd3; scale = 3'd2; end
			ftcr_pkg::EDGE_5: begin edges_needed = 3'd5; scale = 3'd1; end
			// reserved code: measure one period, unscaled
			default:          begin edges_needed = 3'd2; scale = 3'd1; end
		endcase
		if (ctrl_ff[ftcr_pkg::CTRL_PWM_360K]) begin
			scale = 3'd1;
		end
	end

	assign period_sum = {1'b0, period_ff} + {14'h0000, scale};
	assign meas_evt   = tach_edge && (edge_cnt_ff + 3'd1 == edges_needed);

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			tick_cnt_ff <= '0;
			tach_d_ff   <= 1'b1; // pin idles high on its pull-up, so no false edge
		end else begin
			tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 1'b1;
			tach_d_ff   <= i_alert_tach_in;
		end
	end

	// first edge opens the window, the last edge closes and reopens it
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			edge_cnt_ff <= 3'd0;
			period_ff   <= 16'h0000;
			meas_ff     <= 16'hFFFF;
		end else if (!cfg_ff[ftcr_pkg::CFG_TACH_SEL]) begin
			edge_cnt_ff <= 3'd0;
			period_ff   <= 16'h0000;
		end else if (meas_evt) begin
			meas_ff     <= period_ff;
			period_ff   <= 16'h0000;
			edge_cnt_ff <= 3'd1;
		end else begin
			if (tach_edge) begin
				edge_cnt_ff <= edge_cnt_ff + 3'd1;
			end
			if (tick && edge_cnt_ff != 3'd0) begin
				period_ff <= period_sum[16] ? 16'hFFFF : period_sum[15:0];
			end
			// a stalled fan shows as full count without waiting for an edge
			if (period_ff == 16'hFFFF) begin
				meas_ff <= 16'hFFFF;
			end
		end
	end

	//--------------------------------------------------------------
	// high byte freeze on low byte read
	//--------------------------------------------------------------
	logic       frozen_ff;
	logic [7:0] hi_hold_ff;
	logic       rd_lo;
	logic       rd_hi;

	assign rd_lo = setup && !i_pwrite && hi_word_ok && idx == ftcr_pkg::IDX_CNT_LO;
	assign rd_hi = setup && !i_pwrite && hi_word_ok && idx == ftcr_pkg::IDX_CNT_HI;

	// relies on the host reading low first
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			frozen_ff  <= 1'b0;
			hi_hold_ff <= 8'h00;
		end else if (rd_lo) begin
			frozen_ff  <= 1'b1;
			hi_hold_ff <= meas_ff[15:8];
		end else if (rd_hi) begin
			frozen_ff  <= 1'b0;
		end
	end

	//--------------------------------------------------------------
	// interrupts
	//--------------------------------------------------------------
	logic [ftcr_pkg::IRQ_W-1:0] irq_stat_ff;
	logic [ftcr_pkg::IRQ_W-1:0] irq_mask_ff;
	logic [ftcr_pkg::IRQ_W-1:0] irq_set;
	logic [ftcr_pkg::IRQ_W-1:0] irq_clr;

	assign irq_set = {meas_evt, alert_evt};
	assign irq_clr = (wr_en && idx_ok && idx == ftcr_pkg::IDX_IRQ_STAT) ?
	                 i_pwdata[ftcr_pkg::IRQ_W-1:0] : '0;

	// a set in the same cycle as its clear wins
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			irq_stat_ff <= '0;
			irq_mask_ff <= '0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
			if (wr_en && idx_ok && idx == ftcr_pkg::IDX_IRQ_MASK) begin
				irq_mask_ff <= i_pwdata[ftcr_pkg::IRQ_W-1:0];
			end
		end
	end
	assign o_irq = |(irq_stat_ff & irq_mask_ff);

	//--------------------------------------------------------------
	// read data, loaded in the setup cycle
	//--------------------------------------------------------------
	logic [7:0] rd_byte;

	always_comb begin
		case (idx)
			ftcr_pkg::IDX_CFG:      rd_byte = cfg_ff;
			ftcr_pkg::IDX_CRIT:     rd_byte = crit_ff;
			ftcr_pkg::IDX_CNT_LO:   rd_byte = {meas_ff[7:2], edge_sel_ff};
			ftcr_pkg::IDX_CNT_HI:   rd_byte = frozen_ff ? hi_hold_ff : meas_ff[15:8];
			ftcr_pkg::IDX_CTRL:     rd_byte = {6'h00, ctrl_ff};
			ftcr_pkg::IDX_HI_LIM:   rd_byte = hi_lim_ff;
			ftcr_pkg::IDX_LO_LIM:   rd_byte = lo_lim_ff;
			ftcr_pkg::IDX_IRQ_STAT: rd_byte = {6'h00, irq_stat_ff};
			ftcr_pkg::IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_ff};
			default:                rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else if (setup) begin
			o_prdata  <= (idx_ok && !i_pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			o_pslverr <= !idx_ok;
		end
	end
endmodule
`default_nettype wire

// ### verif/ftcr_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ftcr_checker #(
	parameter int AW = 12
) (
	input wire logic          i_ref_clk,
	input wire logic          i_reset,
	input wire logic          i_psel,
	input wire logic          i_penable,
	input wire logic          i_pwrite,
	input wire logic [AW-1:0] i_paddr,
	input wire logic          i_pwm_wave,
	input wire logic          i_conv_done,
	input wire logic [31:0]   o_prdata,
	input wire logic          o_pslverr,
	input wire logic          o_pwm,
	input wire logic          o_continuous,
	input wire logic          o_conv_start,
	input wire logic [7:0]    o_critical_temp_limit,
	input wire logic          o_alert_tach_out,
	input wire logic          o_alert_tach_oe
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	logic rd_s;
	logic wr_a;
	logic lock_ff;
	assign rd_s = i_psel && !i_penable && !i_pwrite;
	assign wr_a = i_psel && i_penable && i_pwrite;
	// limit counts as locked once it has moved away from its reset value
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset)
			lock_ff <= 1'b0;
		else if ($changed(o_critical_temp_limit))
			lock_ff <= 1'b1;
	end
	a_cfg_zero: assert property (rd_s && i_paddr == 12'h00C |=> o_prdata[4:3] == 2'b00)
		else $error("config bits 4:3 read nonzero");
	a_oneshot_pulse: assert property (wr_a && i_paddr == 12'h03C |=> o_conv_start ##1 !o_conv_start)
		else $error("conversion start pulse wrong");
	a_start_cause: assert property (o_conv_start |-> $past(wr_a && i_paddr == 12'h03C))
		else $error("conversion start without trigger write");
	a_crit_gate: assert property ($changed(o_critical_temp_limit) |-> $past(wr_a && i_paddr == 12'h064))
		else $error("critical limit moved without write");
	a_crit_lock: assert property (lock_ff |-> $stable(o_critical_temp_limit))
		else $error("critical limit changed twice");
	a_pwm_follow: assert property (o_continuous |-> o_pwm == i_pwm_wave)
		else $error("pwm not passed through");
	a_open_drain: assert property (o_alert_tach_out == 1'b0)
		else $error("shared pin driven high");
	a_unmapped_err: assert property (rd_s && i_paddr == 12'h3FC |=> o_pslverr [*2])
		else $error("unmapped read without error");
	a_oe_cause: assert property ($rose(o_alert_tach_oe) |-> $past(i_conv_done) || $past(wr_a))
		else $error("alert asserted without cause");
endmodule
bind ftcr_top ftcr_checker #(.AW(AW)) i_chk (
	.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwm_wave(i_pwm_wave), .i_conv_done(i_conv_done),
	.o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_pwm(o_pwm), .o_continuous(o_continuous),
	.o_conv_start(o_conv_start), .o_critical_temp_limit(o_critical_temp_limit),
	.o_alert_tach_out(o_alert_tach_out), .o_alert_tach_oe(o_alert_tach_oe)
);
`default_nettype wire

// ### verif/ftcr_fan_model.sv
`timescale 1ns/10ps
`default_nettype none
module ftcr_fan_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_run,
	input  wire logic [15:0] i_period,
	output logic             o_tach
);
	logic [15:0] cnt_ff;
	// a stopped fan leaves the pulled-up line high
	always_ff @(posedge i_ref_clk) begin
		if (!i_run || cnt_ff >= i_period - 16'h0001)
			cnt_ff <= 16'h0000;
		else
			cnt_ff <= cnt_ff + 16'h0001;
		o_tach <= !i_run || cnt_ff >= (i_period >> 2);
	end
endmodule
`default_nettype wire

// ### verif/ftcr_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
	$display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module ftcr_tb;
	typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] x; logic e;} ftcr_row_t;
	logic clk, rst, psel, pen, pwr, rdy, err, pwm_w, pwm, cont, cst, cdn, od, oe, irq, fan, run, er;
	logic [11:0] pa;
	logic [31:0] pwd, prd;
	logic [7:0]  tmp, crit, rd;
	logic [15:0] per, m;
	int          err_total, checked, cyc;
	ftcr_row_t   rows[9] = '{'{0, 8'h03, 0, 8'h00, 0}, '{1, 8'h03, 8'h18, 0, 0}, '{0, 8'h03, 0, 8'h00, 0},
		'{0, 8'h19, 0, 8'h55, 0}, '{1, 8'h19, 8'h70, 0, 0}, '{0, 8'h19, 0, 8'h55, 0},
		'{0, 8'hFF, 0, 8'h00, 1}, '{0, 8'h47, 0, 8'hFF, 0}, '{0, 8'h46, 0, 8'hFC, 0}};
	ftcr_top #(.TICK_DIV(4), .AW(12)) i_dut (.i_ref_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_pready(rdy), .o_prdata(prd), .o_pslverr(err),
		.i_pwm_wave(pwm_w), .o_pwm(pwm), .o_continuous(cont), .o_conv_start(cst), .i_conv_done(cdn),
		.i_remote_temp(tmp), .o_critical_temp_limit(crit), .i_alert_tach_in(oe ? od : fan),
		.o_alert_tach_out(od), .o_alert_tach_oe(oe), .o_irq(irq));
	ftcr_fan_model i_fan (.i_ref_clk(clk), .i_run(run), .i_period(per), .o_tach(fan));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task conclude();
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		pwm_w <= cyc[0];
		if (cyc == 95000) begin
			err_total++;
			conclude();
		end
	end
	// ----
	// host tasks
	// ----
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1; pen <= 0; pwr <= w; pa <= {2'b00, a, 2'b00}; pwd <= {24'h00_0000, d};
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (rdy !== 1'b1) @(posedge clk);
		rd = prd[7:0];
		er = err;
		psel <= 0;
		pen <= 0;
		#1;
	endtask
	task conv(input logic [7:0] t);
		@(posedge clk);
		tmp <= t; cdn <= 1;
		@(posedge clk);
		cdn <= 0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// wait for fresh periods, then read low byte before high
	task meas(input logic [1:0] c, input logic [7:0] ctl, input int x);
		apb(1, 8'h60, ctl); apb(1, 8'h46, {6'h00, c});
		repeat (4000) @(posedge clk);
		apb(0, 8'h46, 0); m[7:0] = {rd[7:2], 2'b00}; `CHK(rd[1:0], c)
		apb(0, 8'h47, 0); m[15:8] = rd;
		`CHK(m + 8 >= x && m <= x + 8, 1'b1)
	endtask
	initial begin
		{rst, psel, pen, pwr, pa, pwd, cdn, tmp, run, cyc, err_total, checked} = '0;
		rst = 1; per = 16'd400;
		repeat (3) @(posedge clk);
		rst <= 0;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) `CHK(rd, rows[i].x)
			`CHK(er, rows[i].e)
		end
		apb(1, 8'h03, 8'h02); apb(1, 8'h19, 8'h5A); `CHK(crit, 8'h5A)
		apb(1, 8'h19, 8'h40); apb(0, 8'h19, 0); `CHK(rd, 8'h5A)
		apb(1, 8'h03, 8'h00); apb(1, 8'h64, 8'h01);
		conv(8'h50); `CHK(oe, 1'b1) `CHK(irq, 1'b1)
		conv(8'h10); `CHK(oe, 1'b0)
		apb(1, 8'h63, 8'h01); `CHK(irq, 1'b0)
		conv(8'hF0); `CHK(oe, 1'b1)
		apb(1, 8'h03, 8'h01); conv(8'h10); conv(8'h50); conv(8'h50); `CHK(oe, 1'b0)
		conv(8'h50); `CHK(oe, 1'b1)
		apb(1, 8'h03, 8'h05); `CHK(oe, 1'b0)
		@(posedge clk);
		run <= 1;
		meas(2'h2, 0, 400); meas(2'h3, 0, 400); meas(2'h1, 8'h02, 100); meas(2'h1, 0, 400);
		apb(0, 8'h63, 0); `CHK(rd, 8'h03)
		apb(0, 8'h46, 0);
		@(posedge clk);
		per <= 16'd1200;
		repeat (4000) @(posedge clk);
		apb(0, 8'h47, 0); `CHK(rd, 8'h01)
		apb(0, 8'h47, 0); `CHK(rd, 8'h04)
		// stalled fan: the period count must stick at full scale
		@(posedge clk);
		run <= 0;
		repeat (66000) @(posedge clk);
		apb(0, 8'h46, 0); `CHK(rd, 8'hFD)
		apb(0, 8'h47, 0); `CHK(rd, 8'hFF)
		apb(1, 8'h60, 8'h01); apb(1, 8'h03, 8'h65); `CHK(pwm, 1'b1) `CHK(cont, 1'b0)
		@(posedge clk); #1 `CHK(pwm, 1'b1)
		apb(1, 8'h03, 8'h45); `CHK(pwm, pwm_w)
		@(posedge clk); #1 `CHK(pwm, pwm_w)
		apb(1, 8'h0F, 8'h00); `CHK(cst, 1'b1)
		@(posedge clk);
		rst <= 1;
		repeat (3) @(posedge clk);
		rst <= 0;
		apb(0, 8'h19, 0); `CHK(rd, 8'h55)
		apb(1, 8'h03, 8'h02); apb(1, 8'h19, 8'h33); `CHK(crit, 8'h33)
		conclude();
	end
endmodule
`default_nettype wire
